//--- rtl/ndc_core.sv
// Node discovery and configuration logic: settings, discovery exchange
// and formatting of discovery results toward the host.
// Assumes radio-side and host-side handshakes run on ref_clk.
//
// Overview of operation
// - Framing mode 0..3, reset 0; out-of-range writes ignored.
// - Mode 0 inserts extra header enabling discovery, duplicates, retries.
// - Without extra header, discovery and destination lookup are disabled.
// - Modes 1 and 3 disable MAC and clear-channel retries.
// - Without extra header, failed encrypted payloads go to the host.
// - Source address resets 0; FFFF refuses short-addressed frames.
// - Parity select 0..4, reset 0, read back in config bits 4:2.
// - Parity only selects framing; no parity is computed or checked.
// - Discovery sends a global long-addressed packet on current network.
// - Filtered requests get a reply only when our identifier matches.
// - Window is setting times 100 ms, 01..FC, reset 19, sent along.
// - A responder waits a random hold-off of at most 2.2 s.
// - Hold-off bound is received window minus 250 ms.
// - Responses after the window closes are dropped.
// - Text mode ends discovery with one carriage return.
// - Binary mode ends discovery with an empty OK frame.
// - Text entry: address, serial high, low, strength, name, CRs.
// - Binary entry: 2, 4, 4, 1 bytes then null-ended name.
// - Identifier accepts printable chars, no leading space, ends on CR or 20.
// - Self-response option adds an entry describing this node.
// - Pulse output 0 function 0..2, reset 1.
// - Received analog 0 values drive pulse output 0 when bound.
// - Only the bound sender changes outputs; FFFF accepts any sender.
module ndc_core
	import ndc_pkg::*;
#(
	parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [7:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic      [31:0]  wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic [15:0]  serial_number_high_lo,
	input  wire logic [31:0]  serial_number_high,
	input  wire logic [31:0]  serial_number_low,
	input  wire logic         rx_frame_valid,
	input  wire logic         rx_frame_short,
	input  wire logic [15:0]  rx_frame_dst16,
	output logic              rx_frame_accept,
	input  wire logic         rx_req_valid,
	input  wire logic [7:0]   rx_req_window,
	input  wire logic         rx_req_filtered,
	input  wire logic [159:0] rx_req_name,
	input  wire logic [4:0]   rx_req_name_len,
	input  wire logic         rx_resp_valid,
	input  wire logic [15:0]  rx_resp_src,
	input  wire logic [31:0]  rx_resp_ser_hi,
	input  wire logic [31:0]  rx_resp_ser_lo,
	input  wire logic [7:0]   rx_resp_strength,
	input  wire logic [159:0] rx_resp_name,
	input  wire logic [4:0]   rx_resp_name_len,
	output logic              rx_resp_ready,
	input  wire logic         rx_io_valid,
	input  wire logic [15:0]  rx_io_src,
	input  wire logic [9:0]   rx_io_analog_input_zero,
	input  wire logic [7:0]   received_signal_strength,
	output logic              tx_disc_req,
	output logic              tx_disc_long_addr,
	output logic              tx_disc_filtered,
	output logic [7:0]        tx_disc_window,
	output logic              tx_disc_resp,
	output logic              hdr_insert,
	output logic              destination_node_lookup,
	output logic              retries_enable,
	output logic              pass_bad_crypto,
	output logic [2:0]        uart_parity_select,
	output logic [1:0]        pulse_out0_function,
	output logic [9:0]        pulse_output_zero,
	output logic [7:0]        host_byte,
	output logic              host_byte_valid,
	input  wire logic         host_byte_ready,
	output logic              host_end_ok
);
	typedef enum {REQ_IDLE, REQ_COPY, REQ_OPEN, REQ_DRAIN, REQ_END} ndc_req_t;
	typedef enum {RSP_IDLE, RSP_CMP, RSP_HOLD} ndc_rsp_t;
	typedef enum {F_IDLE, F_FIELD, F_SEP, F_NAME, F_TAIL, F_END} ndc_fmt_t;

	logic [1:0]   mac_framing_mode_ff;
	logic [2:0]   parity_select_ff;
	logic         self_resp_ff, bin_mode_ff;
	logic [1:0]   pulse_fn_ff;
	logic [15:0]  short_source_address_ff, io_input_binding_address_ff;
	logic [7:0]   discover_window_time_ff;
	logic [4:0]   name_len_ff;
	logic         name_open_ff;
	logic         ack_ff;
	logic [31:0]  rdat_ff;
	ndc_req_t     req_ff;
	ndc_rsp_t     rsp_ff;
	ndc_fmt_t     fmt_ff;
	logic [16:0]  ms_cnt_ff;
	logic         ms_tick;
	logic [14:0]  win_ms_ff, hold_ms_ff;
	logic [4:0]   copy_idx_ff, cmp_idx_ff;
	logic         cmp_phase_ff, cmp_ok_ff;
	logic [159:0] self_name_ff, req_name_ff, name_sh_ff;
	logic [4:0]   req_len_ff, name_left_ff;
	logic [15:0]  lfsr_ff;
	logic [87:0]  ent_ff;
	logic [1:0]   fld_ff, tail_ff;
	logic [3:0]   units_ff;
	logic         ent_start, end_start, out_free;
	logic [7:0]   out_byte;
	logic [4:0]   rd_addr;
	logic [7:0]   rd_data;
	logic         wr_acc, name_we, hdr_on;
	logic [7:0]   wch;
	logic [14:0]  limit_ms, rnd_ms, hold_pick;
	logic [16:0]  limit_raw;

	// Both vendor-header modes carry the extra header
	assign hdr_on = mac_framing_mode_ff == MODE_RST ||
		mac_framing_mode_ff == MODE_HDR_NA;
	assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
	assign wch    = wb_dat_i[7:0];
	assign name_we = wr_acc && wb_adr_i == OFS_NAME && wb_sel_i[0] &&
		name_open_ff && wch >= CH_SPACE && wch <= CH_TILDE &&
		!(name_len_ff == '0 && wch == CH_SPACE);
	assign rd_addr = (rsp_ff == RSP_CMP) ? cmp_idx_ff : copy_idx_ff;

	ndc_name_mem #(.DEPTH(NAME_MAX), .AW(NAME_AW)) u_name (
		.ref_clk    (ref_clk),
		.wr_en      (name_we),
		.wr_addr    (name_len_ff),
		.wr_data    (wch),
		.rd_addr    (rd_addr),
		.rd_data_ff (rd_data)
	);

	// Wishbone slave: one wait state, unmapped reads return zero
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ack_ff  <= 1'b0;
			rdat_ff <= '0;
		end else begin
			ack_ff  <= wb_cyc_i && wb_stb_i && !ack_ff;
			case (wb_adr_i)
			OFS_CONFIG:   rdat_ff <= {23'h0, bin_mode_ff, pulse_fn_ff,
				self_resp_ff, parity_select_ff, mac_framing_mode_ff};
			OFS_SRC_ADDR: rdat_ff <= {16'h0, short_source_address_ff};
			OFS_WINDOW:   rdat_ff <= {24'h0, discover_window_time_ff};
			OFS_IO_BIND:  rdat_ff <= {16'h0, io_input_binding_address_ff};
			OFS_NAME:     rdat_ff <= {26'h0, name_open_ff, name_len_ff};
			OFS_STATUS:   rdat_ff <= {28'h0, fmt_ff != F_IDLE,
				rsp_ff != RSP_IDLE, req_ff != REQ_IDLE, hdr_on};
			default:      rdat_ff <= '0;
			endcase
		end
	end

	// Settings; out-of-range values leave the old setting in place
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mac_framing_mode_ff         <= MODE_RST;
			parity_select_ff            <= PAR_RST;
			self_resp_ff                <= 1'b0;
			pulse_fn_ff                 <= PWM_RST;
			bin_mode_ff                 <= 1'b0;
			short_source_address_ff     <= SRC_RST;
			discover_window_time_ff     <= WIN_RST;
			io_input_binding_address_ff <= ADDR_ALL;
		end else if (wr_acc && wb_sel_i[0]) begin
			case (wb_adr_i)
			OFS_CONFIG: begin
				mac_framing_mode_ff <= wb_dat_i[CFG_MODE_LSB +: 2];
				if (wb_dat_i[CFG_PAR_LSB +: 3] <= PAR_MAX)
					parity_select_ff <= wb_dat_i[CFG_PAR_LSB +: 3];
				self_resp_ff <= wb_dat_i[CFG_SELF_BIT];
				if (wb_dat_i[CFG_PWM_LSB +: 2] <= PWM_MAX)
					pulse_fn_ff <= wb_dat_i[CFG_PWM_LSB +: 2];
				if (wb_sel_i[1])
					bin_mode_ff <= wb_dat_i[CFG_BIN_BIT];
			end
			OFS_SRC_ADDR:
				if (wb_sel_i[1])
					short_source_address_ff <= wb_dat_i[15:0];
			OFS_WINDOW:
				if (wch >= WIN_MIN && wch <= WIN_MAX)
					discover_window_time_ff <= wch;
			OFS_IO_BIND:
				if (wb_sel_i[1])
					io_input_binding_address_ff <= wb_dat_i[15:0];
			default: ;
			endcase
		end
	end

	// Identifier entry: a write while closed starts a new string
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			name_len_ff  <= '0;
			name_open_ff <= 1'b1;
		end else if (wr_acc && wb_adr_i == OFS_NAME && wb_sel_i[0]) begin
			if (!name_open_ff) begin
				name_open_ff <= 1'b1;
				name_len_ff  <= '0;
			end else if (wch == CH_CR) begin
				name_open_ff <= 1'b0;
			end else if (name_we) begin
				name_len_ff <= name_len_ff + 5'h01;
				if (name_len_ff == 5'(NAME_MAX - 1))
					name_open_ff <= 1'b0;
			end
		end
	end

	// Frame filtering and link-level options
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rx_frame_accept <= 1'b0;
			hdr_insert <= 1'b1;
			destination_node_lookup <= 1'b1;
			retries_enable <= 1'b1;
			pass_bad_crypto <= 1'b0;
			uart_parity_select <= PAR_RST;
			pulse_out0_function <= PWM_RST;
		end else begin
			// Long serial addressing always passes
			rx_frame_accept <= rx_frame_valid && (!rx_frame_short ||
				(short_source_address_ff != ADDR_ALL &&
				rx_frame_dst16 == short_source_address_ff));
			hdr_insert <= hdr_on;
			destination_node_lookup <= hdr_on;
			retries_enable <= mac_framing_mode_ff != MODE_PLAIN_NA &&
				mac_framing_mode_ff != MODE_HDR_NA;
			pass_bad_crypto <= !hdr_on;
			uart_parity_select <= parity_select_ff;
			pulse_out0_function <= pulse_fn_ff;
		end
	end

	// Pulse output 0 follows bound analog samples
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			pulse_output_zero <= '0;
		else if (pulse_fn_ff == PWM_PASS && rx_io_valid &&
			(io_input_binding_address_ff == ADDR_ALL ||
			rx_io_src == io_input_binding_address_ff))
			pulse_output_zero <= rx_io_analog_input_zero;
	end

	// Millisecond enable and free-running random source
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_ff <= '0;
			lfsr_ff   <= 16'hACE1;
		end else begin
			ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + 17'h00001;
			lfsr_ff   <= {lfsr_ff[14:0],
				lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
		end
	end
	assign ms_tick = (ms_cnt_ff == 17'(MS_CYCLES - 1));

	// Hold-off bound: received window less trim, capped
	assign limit_raw = 17'(rx_req_window * WIN_UNIT_MS);
	always_comb begin
		limit_ms = '0;
		if (limit_raw > 17'(HOLD_TRIM_MS))
			limit_ms = 15'(limit_raw - 17'(HOLD_TRIM_MS));
		if (limit_ms > 15'(HOLD_MAX_MS))
			limit_ms = 15'(HOLD_MAX_MS);
		rnd_ms = {3'h0, lfsr_ff[11:0]};
		hold_pick = (rnd_ms > limit_ms) ? rnd_ms - limit_ms : rnd_ms;
		if (hold_pick > limit_ms)
			hold_pick = limit_ms;
	end

	// Responder: optional name match, then random hold-off
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rsp_ff <= RSP_IDLE;
			cmp_idx_ff <= '0;
			cmp_phase_ff <= 1'b0;
			cmp_ok_ff <= 1'b0;
			hold_ms_ff <= '0;
			req_name_ff <= '0;
			req_len_ff <= '0;
			tx_disc_resp <= 1'b0;
		end else begin
			tx_disc_resp <= 1'b0;
			case (rsp_ff)
			RSP_IDLE:
				if (rx_req_valid && hdr_on) begin
					hold_ms_ff <= hold_pick;
					req_name_ff <= rx_req_name;
					req_len_ff <= rx_req_name_len;
					cmp_idx_ff <= '0;
					cmp_phase_ff <= 1'b0;
					cmp_ok_ff <= rx_req_name_len == name_len_ff;
					rsp_ff <= rx_req_filtered ? RSP_CMP : RSP_HOLD;
				end
			RSP_CMP:
				if (cmp_idx_ff == req_len_ff || !cmp_ok_ff)
					rsp_ff <= cmp_ok_ff ? RSP_HOLD : RSP_IDLE;
				else if (!cmp_phase_ff)
					cmp_phase_ff <= 1'b1;
				else begin
					cmp_phase_ff <= 1'b0;
					cmp_ok_ff <= rd_data == req_name_ff[7:0];
					req_name_ff <= req_name_ff >> 8;
					cmp_idx_ff <= cmp_idx_ff + 5'h01;
				end
			RSP_HOLD:
				if (hold_ms_ff == '0) begin
					tx_disc_resp <= 1'b1;
					rsp_ff <= RSP_IDLE;
				end else if (ms_tick)
					hold_ms_ff <= hold_ms_ff - 15'h0001;
			default: rsp_ff <= RSP_IDLE;
			endcase
		end
	end

	// Requester: copy own name, open window, drain, end marker
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			req_ff <= REQ_IDLE;
			copy_idx_ff <= '0;
			self_name_ff <= '0;
			win_ms_ff <= '0;
			tx_disc_req <= 1'b0;
			tx_disc_long_addr <= 1'b0;
			tx_disc_filtered <= 1'b0;
			tx_disc_window <= WIN_RST;
		end else begin
			tx_disc_req <= 1'b0;
			case (req_ff)
			REQ_IDLE:
				if (wr_acc && wb_adr_i == OFS_COMMAND && wb_sel_i[0] &&
					wb_dat_i[CMD_GO_BIT] && hdr_on) begin
					tx_disc_req <= 1'b1;
					tx_disc_long_addr <= 1'b1;
					tx_disc_filtered <= wb_dat_i[CMD_FILT_BIT];
					tx_disc_window <= discover_window_time_ff;
					win_ms_ff <= 15'(discover_window_time_ff * WIN_UNIT_MS);
					copy_idx_ff <= '0;
					self_name_ff <= '0;
					req_ff <= REQ_COPY;
				end
			REQ_COPY:
				// Name read waits while the responder owns the port
				if (rsp_ff != RSP_CMP) begin
					if (copy_idx_ff != '0)
						self_name_ff[(copy_idx_ff - 5'h01) * 8 +: 8] <=
							rd_data;
					if (copy_idx_ff == name_len_ff)
						req_ff <= REQ_OPEN;
					else
						copy_idx_ff <= copy_idx_ff + 5'h01;
				end
			REQ_OPEN:
				if (win_ms_ff == '0)
					req_ff <= REQ_DRAIN;
				else if (ms_tick)
					win_ms_ff <= win_ms_ff - 15'h0001;
			REQ_DRAIN:
				if (fmt_ff == F_IDLE)
					req_ff <= REQ_END;
			REQ_END:
				if (fmt_ff == F_IDLE)
					req_ff <= REQ_IDLE;
			default: req_ff <= REQ_IDLE;
			endcase
		end
	end

	// Self entry is posted as the name copy completes; then peer entries
	assign ent_start = (req_ff == REQ_COPY && rsp_ff != RSP_CMP &&
		copy_idx_ff == name_len_ff && self_resp_ff) ||
		(req_ff == REQ_OPEN && rx_resp_valid && rx_resp_ready);
	assign end_start = (req_ff == REQ_END && fmt_ff == F_IDLE);
	assign out_free = !host_byte_valid || host_byte_ready;

	function automatic logic [3:0] ndc_units(input logic [1:0] f,
		input logic bin);
		logic [3:0] n;
		case (f)
		2'h0:    n = 4'h4;
		2'h3:    n = 4'h2;
		default: n = 4'h8;
		endcase
		ndc_units = bin ? n >> 1 : n;
	endfunction : ndc_units

	function automatic logic [7:0] ndc_hex(input logic [3:0] v);
		ndc_hex = (v < 4'hA) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
	endfunction : ndc_hex

	always_comb begin
		out_byte = CH_CR;
		case (fmt_ff)
		F_FIELD: out_byte = bin_mode_ff ? ent_ff[87:80] :
			ndc_hex(ent_ff[87:84]);
		F_NAME:  out_byte = name_sh_ff[7:0];
		F_TAIL:  out_byte = bin_mode_ff ? CH_NUL : CH_CR;
		default: out_byte = CH_CR;
		endcase
	end

	// Entry formatter and host byte stream
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fmt_ff <= F_IDLE;
			ent_ff <= '0;
			fld_ff <= '0;
			units_ff <= '0;
			tail_ff <= '0;
			name_sh_ff <= '0;
			name_left_ff <= '0;
			host_byte <= CH_CR;
			host_byte_valid <= 1'b0;
			host_end_ok <= 1'b0;
			rx_resp_ready <= 1'b0;
		end else begin
			host_end_ok <= 1'b0;
			if (host_byte_valid && host_byte_ready)
				host_byte_valid <= 1'b0;
			rx_resp_ready <= fmt_ff == F_IDLE && !ent_start;
			case (fmt_ff)
			F_IDLE:
				if (ent_start) begin
					fld_ff <= '0;
					units_ff <= ndc_units(2'h0, bin_mode_ff);
					tail_ff <= bin_mode_ff ? 2'h1 : 2'h2;
					fmt_ff <= F_FIELD;
					if (req_ff == REQ_COPY) begin
						ent_ff <= {short_source_address_ff,
							serial_number_high, serial_number_low,
							received_signal_strength};
						name_sh_ff <= self_name_ff;
						// Last character is still on the read port
						if (name_len_ff != '0)
							name_sh_ff[(name_len_ff - 5'h01) * 8 +: 8] <= rd_data;
						name_left_ff <= name_len_ff;
					end else begin
						ent_ff <= {rx_resp_src, rx_resp_ser_hi,
							rx_resp_ser_lo, rx_resp_strength};
						name_sh_ff <= rx_resp_name;
						name_left_ff <= rx_resp_name_len;
					end
				end else if (end_start)
					fmt_ff <= F_END;
			F_FIELD:
				if (out_free) begin
					host_byte <= out_byte;
					host_byte_valid <= 1'b1;
					ent_ff <= bin_mode_ff ? ent_ff << 8 : ent_ff << 4;
					units_ff <= units_ff - 4'h1;
					if (units_ff == 4'h1) begin
						fld_ff <= fld_ff + 2'h1;
						units_ff <= ndc_units(fld_ff + 2'h1, bin_mode_ff);
						if (!bin_mode_ff)
							fmt_ff <= F_SEP;
						else if (fld_ff == 2'h3)
							fmt_ff <= F_NAME;
					end
				end
			F_SEP:
				if (out_free) begin
					host_byte <= CH_CR;
					host_byte_valid <= 1'b1;
					fmt_ff <= (fld_ff == 2'h0) ? F_NAME : F_FIELD;
				end
			F_NAME:
				if (name_left_ff == '0)
					fmt_ff <= F_TAIL;
				else if (out_free) begin
					host_byte <= out_byte;
					host_byte_valid <= 1'b1;
					name_sh_ff <= name_sh_ff >> 8;
					name_left_ff <= name_left_ff - 5'h01;
				end
			F_TAIL:
				if (out_free) begin
					host_byte <= out_byte;
					host_byte_valid <= 1'b1;
					tail_ff <= tail_ff - 2'h1;
					if (tail_ff == 2'h1)
						fmt_ff <= F_IDLE;
				end
			F_END:
				if (bin_mode_ff) begin
					host_end_ok <= 1'b1;
					fmt_ff <= F_IDLE;
				end else if (out_free) begin
					host_byte <= CH_CR;
					host_byte_valid <= 1'b1;
					fmt_ff <= F_IDLE;
				end
			default: fmt_ff <= F_IDLE;
			endcase
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	AST_ACK_ONE: assert property (@(posedge ref_clk) disable iff (!rstn)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	AST_PARITY_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn)
		parity_select_ff <= PAR_MAX) else $error("parity out of range");
	AST_NO_RETRY: assert property (@(posedge ref_clk) disable iff (!rstn)
		(mac_framing_mode_ff == MODE_PLAIN_NA ||
		mac_framing_mode_ff == MODE_HDR_NA) |=> !retries_enable)
		else $error("retries left on");
	AST_NO_DISC: assert property (@(posedge ref_clk) disable iff (!rstn)
		!hdr_on |=> !tx_disc_req) else $error("discovery without header");
	AST_LATE_DROP: assert property (@(posedge ref_clk) disable iff (!rstn)
		(req_ff != REQ_OPEN && req_ff != REQ_COPY && fmt_ff == F_IDLE)
		|=> fmt_ff != F_FIELD) else $error("late response formatted");
	AST_HOLD_CAP: assert property (@(posedge ref_clk) disable iff (!rstn)
		rsp_ff == RSP_HOLD |-> hold_ms_ff <= 15'(HOLD_MAX_MS))
		else $error("hold-off above cap");
	AST_BYTE_STABLE: assert property (@(posedge ref_clk) disable iff (!rstn)
		host_byte_valid && !host_byte_ready |=>
		host_byte_valid && $stable(host_byte)) else $error("byte dropped");
	AST_NAME_LEN: assert property (@(posedge ref_clk) disable iff (!rstn)
		name_len_ff <= 5'(NAME_MAX)) else $error("identifier too long");
	AST_SHORT_BLOCK: assert property (@(posedge ref_clk) disable iff (!rstn)
		rx_frame_short && short_source_address_ff == ADDR_ALL |=>
		!rx_frame_accept) else $error("short frame accepted");
	AST_PWM_BIND: assert property (@(posedge ref_clk) disable iff (!rstn)
		rx_io_valid && io_input_binding_address_ff != ADDR_ALL &&
		rx_io_src != io_input_binding_address_ff |=> $stable(pulse_output_zero))
		else $error("unbound sender moved output");
endmodule : ndc_core

//--- rtl/ndc_name_mem.sv
// Identifier string storage: one write port, registered read data.
// Assumes the writer never addresses beyond DEPTH-1.
module ndc_name_mem #(
	parameter int unsigned DEPTH = 20,
	parameter int unsigned AW    = 5
) (
	input  wire logic          ref_clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data_ff
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_ff <= mem[rd_addr];
	end
endmodule : ndc_name_mem

//--- rtl/ndc_pkg.sv
// Constants shared by the node discovery and configuration block.
// Assumes a single 125 MHz clock and a classic Wishbone register port.
package ndc_pkg;
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned TICK_MS         = 1;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned WIN_UNIT_MS     = 100;
	localparam int unsigned HOLD_TRIM_MS    = 250;
	localparam int unsigned HOLD_MAX_MS     = 2200;
	localparam int unsigned NAME_MAX        = 20;
	localparam int unsigned NAME_AW         = 5;

	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG      = 8'h00;
	localparam logic [7:0] OFS_SRC_ADDR    = 8'h04;
	localparam logic [7:0] OFS_WINDOW      = 8'h08;
	localparam logic [7:0] OFS_IO_BIND     = 8'h0C;
	localparam logic [7:0] OFS_NAME        = 8'h10;
	localparam logic [7:0] OFS_COMMAND     = 8'h14;
	localparam logic [7:0] OFS_STATUS      = 8'h18;

	// Configuration field positions
	localparam int unsigned CFG_MODE_LSB   = 0;
	localparam int unsigned CFG_PAR_LSB    = 2;
	localparam int unsigned CFG_SELF_BIT   = 5;
	localparam int unsigned CFG_PWM_LSB    = 6;
	localparam int unsigned CFG_BIN_BIT    = 8;
	localparam int unsigned CMD_GO_BIT     = 0;
	localparam int unsigned CMD_FILT_BIT   = 1;

	// Reset values and ranges
	localparam logic [1:0]  MODE_RST       = 2'h0;
	localparam logic [1:0]  MODE_PLAIN_NA  = 2'h1;
	localparam logic [1:0]  MODE_HDR_NA    = 2'h3;
	localparam logic [2:0]  PAR_RST        = 3'h0;
	localparam logic [2:0]  PAR_MAX        = 3'h4;
	localparam logic [1:0]  PWM_RST        = 2'h1;
	localparam logic [1:0]  PWM_MAX        = 2'h2;
	localparam logic [1:0]  PWM_PASS       = 2'h2;
	localparam logic [15:0] SRC_RST        = 16'h0000;
	localparam logic [15:0] ADDR_ALL       = 16'hFFFF;
	localparam logic [7:0]  WIN_RST        = 8'h19;
	localparam logic [7:0]  WIN_MIN        = 8'h01;
	localparam logic [7:0]  WIN_MAX        = 8'hFC;

	// Characters
	localparam logic [7:0]  CH_CR          = 8'h0D;
	localparam logic [7:0]  CH_SPACE       = 8'h20;
	localparam logic [7:0]  CH_TILDE       = 8'h7E;
	localparam logic [7:0]  CH_NUL         = 8'h00;
endpackage : ndc_pkg

//--- sim/ndc_host_model.sv
// Host-side byte sink for the discovery result stream.
// Assumes host_byte/host_byte_valid are registered on ref_clk.
module ndc_host_model (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic [7:0] host_byte,
	input  wire logic       host_byte_valid,
	output logic            host_byte_ready,
	output logic [7:0]      last_byte,
	output logic [7:0]      byte_count
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ready toggles every cycle so the sender must hold its byte
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			host_byte_ready <= 1'b0;
			byte_count      <= 8'h00;
			last_byte       <= 8'h00;
		end else begin
			host_byte_ready <= ~host_byte_ready;
			if (host_byte_valid && host_byte_ready) begin
				byte_count <= byte_count + 8'h01;
				last_byte  <= host_byte;
			end
		end
	end
endmodule : ndc_host_model

//--- sim/testbench.sv
// Self-checking bench: settings over Wishbone, filters and discovery.
// Assumes ndc_core with MS_CYCLES=10, so 100 ms is 1000 cycles.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack, acc;
	logic [7:0] adr = 0, hb, lb, bc;
	logic [31:0] wd = 0, rd, q;
	logic fv = 1, iv = 0, hv, hr, dreq, dla, hdr, rty;
	logic fs = 1, qv = 0, qf = 0, sv = 0, sr, tf, tr, dn, pb, eok;
	logic [7:0] qw = 0, own = 8'h3C, sst = 8'h5A;
	logic [31:0] shi = 32'h0102_0304, ssh = 32'hA0B0_C0D0;
	logic [159:0] qn = 0;
	logic [15:0] ssrc = 16'h0077;
	logic [4:0] ql = 0;
	logic [15:0] fdst = 16'h1234, isrc = 0;
	logic [9:0] ia = 0, pwm;
	logic [7:0] dwin;
	logic [2:0] par;
	logic [1:0] pfn;
	int errors = 0, checks = 0, nresp = 0, nreq = 0, nok = 0;
	always #4 ref_clk = ~ref_clk;
	// One-cycle pulses are counted so checks need not catch them live
	always @(posedge ref_clk) begin
		if (tr === 1'b1)
			nresp <= nresp + 1;
		if (dreq === 1'b1)
			nreq <= nreq + 1;
		if (eok === 1'b1)
			nok <= nok + 1;
	end
	ndc_core #(.MS_CYCLES(10)) ndc_core_i (.ref_clk(ref_clk), .rstn(rstn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.serial_number_high_lo(16'h0000), .serial_number_high(shi),
		.serial_number_low(32'h0), .rx_frame_valid(fv),
		.rx_frame_short(fs), .rx_frame_dst16(fdst),
		.rx_frame_accept(acc), .rx_req_valid(qv),
		.rx_req_window(qw), .rx_req_filtered(qf),
		.rx_req_name(qn), .rx_req_name_len(ql),
		.rx_resp_valid(sv), .rx_resp_src(ssrc), .rx_resp_ser_hi(ssh),
		.rx_resp_ser_lo(32'h0), .rx_resp_strength(sst),
		.rx_resp_name(qn), .rx_resp_name_len(ql), .rx_resp_ready(sr),
		.rx_io_valid(iv), .rx_io_src(isrc), .rx_io_analog_input_zero(ia),
		.received_signal_strength(own), .tx_disc_req(dreq),
		.tx_disc_long_addr(dla), .tx_disc_filtered(tf), .tx_disc_window(dwin),
		.tx_disc_resp(tr), .hdr_insert(hdr), .destination_node_lookup(dn),
		.retries_enable(rty), .pass_bad_crypto(pb),
		.uart_parity_select(par), .pulse_out0_function(pfn),
		.pulse_output_zero(pwm), .host_byte(hb), .host_byte_valid(hv),
		.host_byte_ready(hr), .host_end_ok(eok));
	ndc_host_model ndc_host_model_i (.ref_clk(ref_clk), .rstn(rstn),
		.host_byte(hb), .host_byte_valid(hv), .host_byte_ready(hr),
		.last_byte(lb), .byte_count(bc));
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
		do begin
			@(posedge ref_clk);
		end while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		// Registered outputs follow a write one edge later
		@(posedge ref_clk);
	endtask : bus
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic io(input logic [15:0] s, input logic [9:0] v);
		@(posedge ref_clk);
		iv <= 1'b1; isrc <= s; ia <= v;
		@(posedge ref_clk);
		iv <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : io
	task automatic req(input logic [159:0] n);
		@(posedge ref_clk);
		qn <= n; qv <= 1'b1;
		@(posedge ref_clk);
		qv <= 1'b0;
		repeat (20) @(posedge ref_clk);
	endtask : req
	task automatic resp;
		sv <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (sr !== 1'b1);
		sv <= 1'b0;
		repeat (60) @(posedge ref_clk);
	endtask : resp
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		#400000;
		errors++;
		complete_run;
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		chk({hdr, rty, par, pfn, dwin}, {2'b11, 3'h0, 2'h1, 8'h19});
		bus(0, 8'h00, 0); chk(q[7:0], 8'h40);
		for (int m = 0; m < 4; m++) begin
			bus(1, 8'h00, 32'h40 | m);
			chk({hdr, rty}, {m == 0 || m == 3, !(m == 1 || m == 3)});
			chk({dn, pb}, {m == 0 || m == 3, m == 1 || m == 2});
		end
		bus(1, 8'h00, 32'h50); chk(par, 3'h4);
		bus(1, 8'h00, 32'h54); chk(par, 3'h4);
		bus(0, 8'h08, 0); chk(q[7:0], 8'h19);
		bus(1, 8'h08, 32'hFD); bus(1, 8'h08, 32'h00);
		bus(0, 8'h08, 0); chk(q[7:0], 8'h19);
		bus(1, 8'h04, 32'h1234); repeat (2) @(posedge ref_clk);
		chk(acc, 1'b1);
		fdst <= 16'hFFFF; bus(1, 8'h04, 32'hFFFF);
		repeat (2) @(posedge ref_clk); chk(acc, 1'b0);
		fs <= 1'b0; repeat (2) @(posedge ref_clk);
		chk(acc, 1'b1);
		bus(1, 8'h00, 32'h80); chk(pfn, 2'h2);
		io(16'h0042, 10'h2A5); chk(pwm, 10'h2A5);
		bus(1, 8'h0C, 32'h0005); io(16'h0006, 10'h111);
		chk(pwm, 10'h2A5);
		io(16'h0005, 10'h111); chk(pwm, 10'h111);
		bus(1, 8'h10, 32'h20); bus(1, 8'h10, 32'h41);
		bus(1, 8'h10, 32'h07); bus(1, 8'h10, 32'h42);
		bus(1, 8'h10, 32'h0D); bus(0, 8'h10, 0);
		chk(q[7:0], 8'h02);
		qw <= 8'h01; qf <= 1'b1; ql <= 5'h02;
		req(160'h4142); chk(nresp, 0);
		req(160'h4241); chk(nresp, 1);
		qf <= 1'b0; req(160'h0); chk(nresp, 2);
		qw <= 8'h03; req(160'h0); repeat (600) @(posedge ref_clk);
		chk(nresp, 3);
		bus(1, 8'h08, 32'h01); bus(1, 8'h14, 32'h1);
		chk({dla, tf, dwin}, {2'b10, 8'h01});
		chk(nreq, 1);
		repeat (1300) @(posedge ref_clk);
		chk({bc, lb}, {8'h01, 8'h0D});
		bus(1, 8'h00, 32'h1A0); bus(1, 8'h14, 32'h1);
		repeat (100) @(posedge ref_clk);
		ql <= 5'h00; resp; repeat (1100) @(posedge ref_clk);
		chk(bc, 8'h1B);
		chk(lb, 8'h00);
		chk(nok, 1);
		resp; chk(bc, 8'h1B);
		complete_run;
	end
endmodule : testbench
